//--- wit_params.svh
// Register map, reset values, field positions and timing counts for the watchdog interval timer
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH
// How it works
// RL1: Enable clear holds counter at zero, stopped.
// RL2: Enable set: count on ticks, allow interrupts.
// RL3: Interval mode: overflow requests interval interrupt.
// RL4: Watchdog mode: overflow generates a reset.
// RL5: Overflow flag sets on wrap FF to 00.
// RL6: Overflow flag clears by read-one, write-zero only.
// RL7: Clock select picks divide 2..4096 tick.
// RL8: Reset flag accepts only zero writes.
// RL9: Reset flag clears on pin reset or zero write.
// RL10: Watchdog overflow reset sets reset flag.
// RL11: Output enable drives watchdog reset onto pin.

// Register indices; byte address is four times the index
`define WIT_IDX_CTRL       10'h0A8
`define WIT_IDX_COUNT      10'h0A9
`define WIT_IDX_RSTC       10'h0AB
`define WIT_IDX_IRQ_STAT   10'h0AC
`define WIT_IDX_IRQ_MASK   10'h0AD

// Reset values
`define WIT_CTRL_RESET     8'h18
`define WIT_COUNT_RESET    8'h00
`define WIT_RSTC_RESET     8'h3F
`define WIT_IRQ_RESET      2'h0

// Field positions
`define WIT_CTRL_OVF_BIT   7
`define WIT_CTRL_MODE_BIT  6
`define WIT_CTRL_EN_BIT    5
`define WIT_RSTC_FLAG_BIT  7
`define WIT_RSTC_OE_BIT    6
`define WIT_IRQ_INTERVAL   0
`define WIT_IRQ_WATCHDOG   1

// Counter limits and reset pulse length in system clocks
`define WIT_COUNT_MAX      8'hFF
`define WIT_RST_PULSE_CYC  16
`endif

//--- wit_pkg.sv
// Types shared by the watchdog interval timer
`default_nettype none
package wit_pkg;
   // Timer control and status byte
   typedef struct packed {
      logic       ovf;
      logic       mode;
      logic       en;
      logic [1:0] rsv;
      logic [2:0] cks;
   } wit_ctrl_t;

   // Reset control and status byte
   typedef struct packed {
      logic       flag;
      logic       oe;
      logic [5:0] rsv;
   } wit_rstc_t;

   // Classic Wishbone slave request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } wit_wb_req_t;

   // Reset pulse generator
   typedef enum logic [0:0] {
      WIT_RST_IDLE  = 1'b0,
      WIT_RST_PULSE = 1'b1
   } wit_rst_state_t;
endpackage : wit_pkg
`default_nettype wire

//--- wit_timer.sv
// Watchdog interval timer with classic Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
`include "wit_params.svh"
module wit_timer #(
   parameter int unsigned RST_PULSE_CYC = `WIT_RST_PULSE_CYC
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset_n,
   input  wire wit_pkg::wit_wb_req_t i_wb_req,
   output logic                      o_wb_ack,
   output logic [31:0]               o_wb_dat,
   output logic                      o_irq,
   output logic                      o_reset_int,
   output logic                      o_reset_pin
);
   import wit_pkg::*;

   // Address decode shared by read and write paths
   function automatic logic wit_hit(input logic [11:0] adr, input logic [9:0] idx);
      wit_hit = (adr[11:2] == idx);
   endfunction : wit_hit

   // Prescaler tick: low bits of the divider, which runs only while enabled, all ones
   function automatic logic wit_tick(input logic [2:0] cks, input logic [11:0] pre);
      logic [11:0] mask;
      mask = 12'h000;
      case (cks)
         3'h0:    mask = 12'h001;
         3'h1:    mask = 12'h01F;
         3'h2:    mask = 12'h03F;
         3'h3:    mask = 12'h07F;
         3'h4:    mask = 12'h0FF;
         3'h5:    mask = 12'h1FF;
         3'h6:    mask = 12'h7FF;
         default: mask = 12'hFFF;
      endcase
      wit_tick = ((pre & mask) == mask);
   endfunction : wit_tick

   wit_ctrl_t      ctrl,  next_ctrl;
   wit_rstc_t      rstc,  next_rstc;
   wit_rst_state_t rst_state, next_rst_state;
   logic [7:0]     count, next_count;
   logic [11:0]    prescale, next_prescale;
   logic [1:0]     irq_stat, next_irq_stat;
   logic [1:0]     irq_mask, next_irq_mask;
   logic           ovf_armed, next_ovf_armed;
   logic [7:0]     pulse_cnt, next_pulse_cnt;
   logic           next_ack;
   logic [31:0]    next_rdat;
   logic           next_irq;
   logic           next_reset_int;
   logic           next_reset_pin;

   logic       req;
   logic       wr;
   logic       rd;
   logic       tick;
   logic       count_wr;
   logic       wrap;
   logic       fire;
   logic [7:0] wdata;

   // Bus request qualification; one access per ack
   assign req      = i_wb_req.cyc & i_wb_req.stb & ~o_wb_ack;
   assign wr       = req & i_wb_req.we & i_wb_req.sel[0];
   assign rd       = req & ~i_wb_req.we;
   assign wdata    = i_wb_req.dat[7:0];
   assign count_wr = wr & wit_hit(i_wb_req.adr, `WIT_IDX_COUNT);
   assign tick     = ctrl.en & wit_tick(ctrl.cks, prescale);               // RL7
   // A software load in the tick cycle wins, so no wrap is seen then
   assign wrap     = tick & ~count_wr & (count == `WIT_COUNT_MAX);         // RL5
   assign fire     = wrap & ctrl.mode;                                     // RL4

   // Counter and prescaler
   always_comb begin
      next_prescale = 12'h000;
      next_count    = count;
      if (!ctrl.en) begin
         next_count = `WIT_COUNT_RESET;                                    // RL1
      end else begin
         next_prescale = prescale + 12'h001;
         if (count_wr) begin
            next_count = wdata;
         end else if (tick) begin
            next_count = count + 8'h01;                                    // RL2
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count    <= `WIT_COUNT_RESET;
         prescale <= 12'h000;
      end else begin
         count    <= next_count;
         prescale <= next_prescale;
      end
   end

   // Control, reset status and interrupt registers
   always_comb begin
      next_ctrl      = ctrl;
      next_rstc      = rstc;
      next_ovf_armed = ovf_armed;
      next_irq_stat  = irq_stat;
      next_irq_mask  = irq_mask;
      if (rd && wit_hit(i_wb_req.adr, `WIT_IDX_CTRL) && ctrl.ovf) begin
         next_ovf_armed = 1'b1;
      end
      if (wr && wit_hit(i_wb_req.adr, `WIT_IDX_CTRL)) begin
         next_ctrl.mode = wdata[`WIT_CTRL_MODE_BIT];
         next_ctrl.en   = wdata[`WIT_CTRL_EN_BIT];
         next_ctrl.cks  = wdata[2:0];
         // Only a zero after a read of one clears; a one is ignored
         if (ovf_armed && !wdata[`WIT_CTRL_OVF_BIT]) begin
            next_ctrl.ovf = 1'b0;                                          // RL6
         end
         next_ovf_armed = 1'b0;
      end
      if (wrap) begin
         next_ctrl.ovf = 1'b1;                                             // RL5
      end
      if (wr && wit_hit(i_wb_req.adr, `WIT_IDX_RSTC)) begin
         next_rstc.oe = wdata[`WIT_RSTC_OE_BIT];
         if (!wdata[`WIT_RSTC_FLAG_BIT]) begin
            next_rstc.flag = 1'b0;                                         // RL8 RL9
         end
      end
      if (fire) begin
         next_rstc.flag = 1'b1;                                            // RL10
      end
      if (wr && wit_hit(i_wb_req.adr, `WIT_IDX_IRQ_STAT)) begin
         next_irq_stat = irq_stat & ~wdata[1:0];
      end
      if (wr && wit_hit(i_wb_req.adr, `WIT_IDX_IRQ_MASK)) begin
         next_irq_mask = wdata[1:0];
      end
      // Events set after the clear so the set wins
      if (wrap && !ctrl.mode && ctrl.en) begin
         next_irq_stat[`WIT_IRQ_INTERVAL] = 1'b1;                          // RL3 RL2
      end
      if (fire) begin
         next_irq_stat[`WIT_IRQ_WATCHDOG] = 1'b1;
      end
      next_ctrl.rsv = 2'h3;
      next_rstc.rsv = 6'h3F;
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl      <= `WIT_CTRL_RESET;
         rstc      <= `WIT_RSTC_RESET;                                     // RL9
         ovf_armed <= 1'b0;
         irq_stat  <= `WIT_IRQ_RESET;
         irq_mask  <= `WIT_IRQ_RESET;
         o_irq     <= 1'b0;
      end else begin
         ctrl      <= next_ctrl;
         rstc      <= next_rstc;
         ovf_armed <= next_ovf_armed;
         irq_stat  <= next_irq_stat;
         irq_mask  <= next_irq_mask;
         o_irq     <= next_irq;
      end
   end

   // Reset pulse: a new overflow restarts the full pulse length
   always_comb begin
      next_rst_state = rst_state;
      next_pulse_cnt = pulse_cnt;
      case (rst_state)
         WIT_RST_IDLE: begin
            next_pulse_cnt = 8'h00;
         end
         WIT_RST_PULSE: begin
            if (pulse_cnt == 8'h00) begin
               next_rst_state = WIT_RST_IDLE;
            end else begin
               next_pulse_cnt = pulse_cnt - 8'h01;
            end
         end
         default: begin
            next_rst_state = WIT_RST_IDLE;
            next_pulse_cnt = 8'h00;
         end
      endcase
      if (fire) begin
         next_rst_state = WIT_RST_PULSE;                                   // RL4
         next_pulse_cnt = 8'(RST_PULSE_CYC - 1);
      end
      next_reset_int = (next_rst_state == WIT_RST_PULSE);
      // Pin copy only while the output enable is set
      next_reset_pin = next_reset_int & next_rstc.oe;                      // RL11
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_state   <= WIT_RST_IDLE;
         pulse_cnt   <= 8'h00;
         o_reset_int <= 1'b0;
         o_reset_pin <= 1'b0;
      end else begin
         rst_state   <= next_rst_state;
         pulse_cnt   <= next_pulse_cnt;
         o_reset_int <= next_reset_int;
         o_reset_pin <= next_reset_pin;
      end
   end

   // Bus answer: ack one cycle after the request, unmapped reads give zero
   always_comb begin
      next_ack  = req;
      next_rdat = 32'h0000_0000;
      if (rd) begin
         if (wit_hit(i_wb_req.adr, `WIT_IDX_CTRL)) begin
            next_rdat[7:0] = ctrl;
         end else if (wit_hit(i_wb_req.adr, `WIT_IDX_COUNT)) begin
            next_rdat[7:0] = count;
         end else if (wit_hit(i_wb_req.adr, `WIT_IDX_RSTC)) begin
            next_rdat[7:0] = rstc;
         end else if (wit_hit(i_wb_req.adr, `WIT_IDX_IRQ_STAT)) begin
            next_rdat[1:0] = irq_stat;
         end else if (wit_hit(i_wb_req.adr, `WIT_IDX_IRQ_MASK)) begin
            next_rdat[1:0] = irq_mask;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= next_ack;
         o_wb_dat <= next_rdat;
      end
   end

   // Checks on the timer behaviour
   default clocking wit_cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   sequence s_wdt_fire;
      wrap && ctrl.mode;
   endsequence

   sequence s_rstc_write(logic bit7);
      wr && wit_hit(i_wb_req.adr, `WIT_IDX_RSTC) && (wdata[7] == bit7) && !fire;
   endsequence

   // Read of the control byte while the overflow flag is up
   sequence s_ovf_read;
      rd && wit_hit(i_wb_req.adr, `WIT_IDX_CTRL) && ctrl.ovf;
   endsequence

   // Zero write to the flag with no overflow in the same cycle
   sequence s_ovf_zero_write;
      wr && wit_hit(i_wb_req.adr, `WIT_IDX_CTRL) && !wdata[`WIT_CTRL_OVF_BIT] && !wrap;
   endsequence

   // Timer running at the fastest divider
   sequence s_div2_on;
      ctrl.en && ctrl.cks == 3'h0;
   endsequence

   chk_disabled_zero: assert property (!ctrl.en |=> count == 8'h00) // RL1
      else $error("counter not held at zero while disabled");

   chk_tick_advance: assert property (tick && !count_wr |=> count == $past(count) + 8'h01) // RL2
      else $error("counter did not advance on tick");

   chk_interval_irq: assert property (wrap && !ctrl.mode |=> irq_stat[0] && ctrl.ovf) // RL3
      else $error("interval overflow did not raise request");

   chk_wdt_reset: assert property (s_wdt_fire |=> o_reset_int) // RL4
      else $error("watchdog overflow did not reset");

   chk_ovf_set: assert property (count == 8'hFF && tick && !count_wr |=> ctrl.ovf && count == 8'h00) // RL5
      else $error("overflow flag not set on wrap");

   chk_ovf_one_write: assert property (wr && wit_hit(i_wb_req.adr, `WIT_IDX_CTRL) && wdata[7] // RL6
      && ctrl.ovf |=> ctrl.ovf)
      else $error("write of one changed overflow flag");

   // Two running cycles in a row must toggle the tick; a disable in between is not a fault
   chk_fastest_tick: assert property (s_div2_on ##1 s_div2_on |-> tick != $past(tick)) // RL7
      else $error("divide by two tick spacing wrong");

   chk_flag_no_set: assert property (s_rstc_write(1'b1) ##0 !rstc.flag |=> !rstc.flag) // RL8
      else $error("write of one set reset flag");

   chk_flag_clear: assert property (s_rstc_write(1'b0) |=> !rstc.flag) // RL9
      else $error("write of zero did not clear reset flag");

   chk_flag_set: assert property (s_wdt_fire |=> rstc.flag ##1 rstc.flag || $past(wr)) // RL10
      else $error("watchdog reset did not set flag");

   chk_pin_gate: assert property (o_reset_pin |-> o_reset_int && rstc.oe) // RL11
      else $error("reset pin driven without enable");

   chk_pin_follow: assert property (o_reset_int && rstc.oe |-> o_reset_pin) // RL11
      else $error("enabled reset not driven on pin");

   // The write lands three edges after the read: one ack cycle, then one idle bus cycle
   chk_ovf_clear: assert property (s_ovf_read ##3 s_ovf_zero_write |=> !ctrl.ovf) // RL6
      else $error("read then zero write did not clear overflow");

   chk_interval_no_flag: assert property (wrap && !ctrl.mode && !rstc.flag |=> !rstc.flag) // RL3
      else $error("interval overflow set reset flag");

   // Only a zero write lowers the reset flag; a pin reset is excluded by the disable
   chk_flag_hold: assert property (rstc.flag && !(wr && wit_hit(i_wb_req.adr, `WIT_IDX_RSTC) // RL9
      && !wdata[`WIT_RSTC_FLAG_BIT]) |=> rstc.flag)
      else $error("reset flag fell without a zero write");
endmodule : wit_timer
`default_nettype wire

//--- wit_timer_tb.sv
// Self-checking bench for the watchdog interval timer
`timescale 1ns/10ps
`default_nettype none
`include "wit_params.svh"
module testbench;
   import wit_pkg::*;
   localparam int unsigned RST    = 2;   // Short reset pulse keeps the run brief
   localparam logic [11:0] A_CTRL = {`WIT_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_CNT  = {`WIT_IDX_COUNT, 2'b00};
   localparam logic [11:0] A_RSTC = {`WIT_IDX_RSTC, 2'b00};
   localparam logic [11:0] A_STAT = {`WIT_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_MASK = {`WIT_IDX_IRQ_MASK, 2'b00};
   logic        i_clk_sys;
   logic        i_reset_n;
   wit_wb_req_t i_wb_req;
   logic        o_wb_ack;
   logic [31:0] o_wb_dat;
   logic        o_irq;
   logic        o_reset_int;
   logic        o_reset_pin;
   logic [31:0] q_exp[$];
   string       q_nm[$];
   logic [7:0]  seed;
   int          n_fail = 0;
   int          checks = 0;
   int          n_int  = 0;
   int          n_pin  = 0;
   int          div[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wit_timer #(.RST_PULSE_CYC(RST)) u_wit_timer (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_wb_req    (i_wb_req),
      .o_wb_ack    (o_wb_ack),
      .o_wb_dat    (o_wb_dat),
      .o_irq       (o_irq),
      .o_reset_int (o_reset_int),
      .o_reset_pin (o_reset_pin)
   );

   // Clock at 10 MHz
   always #50 i_clk_sys = ~i_clk_sys;

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string nm);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : check

   task automatic end_of_test;
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   // One classic cycle; random filler rides in the unused upper data bits
   task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e,
                      input string nm);
      int n;
      n = 0;
      q_exp.push_back(we ? 32'h0 : {24'h0, e});
      q_nm.push_back(nm);
      i_wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: {{3{seed}}, d}};
      seed = lfsr_next(seed);
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      i_wb_req.cyc <= 1'b0;
      i_wb_req.stb <= 1'b0;
      @(posedge i_clk_sys);
   endtask : acc

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      acc(1'b1, a, d, 8'h00, "write data");
   endtask : wr

   task automatic idle(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : idle

   // Ack monitor takes the oldest expectation; also counts reset pulse cycles
   always @(posedge i_clk_sys) begin
      if (o_wb_ack === 1'b1) begin
         if (q_exp.size() == 0) check(32'h1, 32'h0, "spurious ack");
         else check(o_wb_dat, q_exp.pop_front(), q_nm.pop_front());
      end
      if (o_reset_int === 1'b1) n_int++;
      if (o_reset_pin === 1'b1) n_pin++;
   end

   // Watchdog on the whole run
   initial begin
      idle(40000);
      n_fail++;
      end_of_test();
   end

   initial begin
      i_clk_sys = 1'b0;
      i_reset_n = 1'b0;
      i_wb_req  = '0;
      seed      = 8'h20;
      idle(5);
      i_reset_n <= 1'b1;
      idle(1);
      acc(0, A_CTRL, 0, 8'h18, "ctrl");
      acc(0, A_RSTC, 0, 8'h3F, "rstc");
      acc(0, A_STAT, 0, 8'h00, "stat");
      acc(0, A_MASK, 0, 8'h00, "mask");
      acc(0, 12'h000, 0, 8'h00, "unmapped");
      wr(A_CNT, seed);
      acc(0, A_CNT, 0, 8'h00, "count off");
      // Interval overflow, then the read-then-write-zero clear
      wr(A_CTRL, 8'h20);
      wr(A_CNT, 8'hFE);
      idle(12);
      acc(0, A_STAT, 0, 8'h01, "stat");
      wr(A_MASK, 8'h01);
      idle(2);
      check({31'h0, o_irq}, 32'h1, "irq on");
      wr(A_CTRL, 8'hA0);
      acc(0, A_CTRL, 0, 8'hB8, "ctrl ovf");
      wr(A_CTRL, 8'h20);
      acc(0, A_CTRL, 0, 8'h38, "ctrl clr");
      wr(A_STAT, 8'h01);
      idle(2);
      check({31'h0, o_irq}, 32'h0, "irq off");
      wr(A_CTRL, 8'h00);
      acc(0, A_CNT, 0, 8'h00, "count off");
      // Each divider from 32 to 4096 gives exactly three ticks in three periods
      for (int k = 1; k < 8; k++) begin
         wr(A_CTRL, {5'b00100, 3'(k)});
         idle(3 * div[k]);
         acc(0, A_CNT, 0, 8'h03, "count ticks");
         wr(A_CTRL, 8'h00);
      end
      // Watchdog overflow with the pin enabled
      wr(A_RSTC, 8'h40);
      wr(A_CTRL, 8'h60);
      wr(A_CNT, 8'hFE);
      idle(12);
      wr(A_CTRL, 8'h00);
      check(32'(n_int), 32'(RST), "int pulse");
      check(32'(n_pin), 32'(RST), "pin pulse");
      acc(0, A_RSTC, 0, 8'hFF, "rstc flag");
      acc(0, A_STAT, 0, 8'h02, "stat wd");
      check({31'h0, o_irq}, 32'h0, "irq masked");
      wr(A_MASK, 8'h03);
      idle(2);
      check({31'h0, o_irq}, 32'h1, "irq wd");
      wr(A_STAT, 8'h02);
      wr(A_RSTC, 8'h80);
      acc(0, A_RSTC, 0, 8'hBF, "rstc one");
      wr(A_RSTC, 8'h00);
      acc(0, A_RSTC, 0, 8'h3F, "rstc zero");
      // Second overflow stays internal, then the pin reset clears the flag
      wr(A_CTRL, 8'h60);
      wr(A_CNT, 8'hFE);
      idle(12);
      wr(A_CTRL, 8'h00);
      check(32'(n_int), 32'(2 * RST), "int pulse");
      check(32'(n_pin), 32'(RST), "pin quiet");
      acc(0, A_RSTC, 0, 8'hBF, "rstc flag");
      i_reset_n <= 1'b0;
      idle(2);
      i_reset_n <= 1'b1;
      idle(1);
      acc(0, A_RSTC, 0, 8'h3F, "rstc pin");
      idle(2);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
